// ==== tpr_pkg.sv ====
// Package: register map, reset values, field layout and carrier types
package tpr_pkg;
  // Register offsets (byte addresses are four times the index)
  localparam logic [7:0] TPR_IDX_PATTERN_CONFIG = 8'h2b;
  localparam logic [7:0] TPR_IDX_PATTERN_MASK   = 8'h2d;
  localparam logic [7:0] TPR_IDX_RECAL_CONFIG   = 8'h2f;
  localparam logic [7:0] TPR_IDX_THRESHOLD_BASE = 8'h30;
  localparam logic [7:0] TPR_IDX_STATUS         = 8'h50;
  // Reset values
  localparam logic [7:0] TPR_RST_PATTERN_CONFIG = 8'h00;
  localparam logic [7:0] TPR_RST_PATTERN_MASK   = 8'h3f;
  localparam logic [7:0] TPR_RST_RECAL_CONFIG   = 8'h8a;
  localparam logic [7:0] TPR_RST_THRESHOLD      = 8'h40;
  // Field positions
  localparam int TPR_POS_DETECT_ENABLE   = 7;
  localparam int TPR_POS_THRESH_SEL      = 2;
  localparam int TPR_POS_COMPARE_SEL     = 1;
  localparam int TPR_POS_ALERT_ENABLE    = 0;
  localparam int TPR_POS_BROADCAST       = 7;
  localparam int TPR_POS_KEEP_ACCUM      = 6;
  localparam int TPR_POS_KEEP_NEG        = 5;
  localparam int TPR_POS_NEG_COUNT       = 3;
  localparam int TPR_POS_CAL_CFG         = 0;
  localparam int TPR_POS_STATUS_INT      = 0;
  localparam int TPR_POS_STATUS_EVENT    = 1;
  localparam int TPR_POS_STATUS_BLOCK    = 2;
  localparam int TPR_INPUTS              = 6;

  // One polling cycle of sensor results
  typedef struct packed {
    logic        valid;
    logic [5:0]  noise;
    logic [6:0]  delta0;
    logic [6:0]  delta1;
    logic [6:0]  delta2;
    logic [6:0]  delta3;
    logic [6:0]  delta4;
    logic [6:0]  delta5;
  } tpr_poll_type;

  // Recalibration settings for the analog back end
  typedef struct packed {
    logic        clear_accum;
    logic        clear_neg;
    logic [5:0]  neg_trigger;
    logic        neg_never;
    logic [8:0]  samples;
    logic [12:0] update_cycles;
  } tpr_recal_type;
endpackage : tpr_pkg

// ==== tpr_recal_decode.sv ====
// Recalibration setting decode from the configuration register
`timescale 1ns/10ps
module tpr_recal_decode
(
  input  wire logic [7:0]            cfg_in,
  input  wire logic                  noise_in,
  output tpr_pkg::tpr_recal_type     recal_out
);
  wire [1:0] neg_code;
  wire [2:0] cal_code;
  wire       keep_accumulation_on_noise;
  wire       keep_negative_counter_on_noise;

  // Field extraction
  assign neg_code = cfg_in[tpr_pkg::TPR_POS_NEG_COUNT +: 2];
  assign cal_code = cfg_in[tpr_pkg::TPR_POS_CAL_CFG +: 3];
  assign keep_accumulation_on_noise =
    cfg_in[tpr_pkg::TPR_POS_KEEP_ACCUM];
  assign keep_negative_counter_on_noise =
    cfg_in[tpr_pkg::TPR_POS_KEEP_NEG];

  // Noise clears unless the keep bits say otherwise
  assign recal_out.clear_accum = noise_in & ~keep_accumulation_on_noise; // R11
  assign recal_out.clear_neg = noise_in & ~keep_negative_counter_on_noise; // R12
  // Negative delta trigger: 8, 16, 32 or never
  assign recal_out.neg_never = (neg_code == 2'h3); // R14
  assign recal_out.neg_trigger = (neg_code == 2'h0) ? 6'h08 :
                                 (neg_code == 2'h1) ? 6'h10 :
                                 (neg_code == 2'h2) ? 6'h20 : 6'h00; // R14
  // Samples saturate at 256 above code 4
  assign recal_out.samples = cal_code[2] ? 9'h100
                           : 9'(9'h010 << cal_code); // R15
  assign recal_out.update_cycles =
    (cal_code <= 3'h4) ? 13'(13'h0010 << cal_code)
                       : 13'(13'h0020 << cal_code); // R15
endmodule : tpr_recal_decode

// ==== tpr_top.sv ====
// Touch pattern detection with recalibration configuration registers
`timescale 1ns/10ps
// Behaviour
// R1: Detection runs only when enable bit set
// R2: Pattern threshold is fraction of touch threshold
// R3: Pattern mode: all masked inputs over threshold
// R4: Count mode: hits at least mask popcount
// R5: Evaluate on one polling cycle's results
// R6: Block touches while the condition holds
// R7: Status cleared only by int clear, condition gone
// R8: Status always set; alert only if enabled
// R9: Mask has six bits, reset 3Fh
// R10: Broadcast write of input-1 threshold
// R11: Noise clears accumulation unless keep bit
// R12: Noise clears negative counter unless keep bit
// R13: Host keeps both keep bits equal
// R14: Negative delta trigger count 8/16/32/never
// R15: Sample count and update period decode
// R16: Disabled detection neither blocks nor flags
module tpr_top
(
  input  wire logic                  mclk_in,
  input  wire logic                  rstn_in,
  input  wire logic [31:0]           wb_adr_in,
  input  wire logic [31:0]           wb_dat_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire logic                  wb_we_in,
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  output logic      [31:0]           wb_dat_out,
  output logic                       wb_ack_out,
  input  wire tpr_pkg::tpr_poll_type poll_in,
  input  wire logic                  standby_in,
  input  wire logic [6:0]            standby_threshold_in,
  input  wire logic                  noise_status_in,
  output logic                       touch_block_out,
  output logic                       alert_n_out,
  output tpr_pkg::tpr_recal_type     recal_out
);
  logic [7:0]              pattern_config;
  logic [5:0]              pattern_mask;
  logic [7:0]              recal_config;
  logic [6:0]              threshold [0:5];
  logic                    pattern_event_flag;
  logic                    int_flag;
  logic                    cond_active;
  tpr_pkg::tpr_recal_type  next_recal;

  // Fraction of a threshold: 1/8, 1/4, 3/8 or whole
  function automatic logic [6:0] frac(input logic [6:0] th,
                                      input logic [1:0] sel);
    logic [9:0] t3;
    t3 = {3'h0, th} + {2'h0, th, 1'b0};
    case (sel)
      2'h0:    frac = {3'h0, th[6:3]};
      2'h1:    frac = {2'h0, th[6:2]};
      2'h2:    frac = t3[9:3];
      default: frac = th;
    endcase
  endfunction : frac

  // Number of ones in a six bit vector
  function automatic logic [2:0] ones(input logic [5:0] v);
    ones = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]) + 3'(v[5]);
  endfunction : ones

  wire        pattern_detect_enable;
  wire [1:0]  pattern_threshold_select;
  wire        pattern_compare_select;
  wire        pattern_alert_enable;
  wire        threshold_broadcast_write;
  wire [6:0]  delta [0:5];
  wire [5:0]  hit;
  wire        pattern_match;
  wire        count_match;
  wire        cond_now;
  wire        wb_req;
  wire        wb_wr;
  wire [7:0]  wb_idx;
  wire        idx_high_zero;
  wire        sel_ok;

  // Configuration field extraction
  assign pattern_detect_enable =
    pattern_config[tpr_pkg::TPR_POS_DETECT_ENABLE]; // R1
  assign pattern_threshold_select =
    pattern_config[tpr_pkg::TPR_POS_THRESH_SEL +: 2];
  assign pattern_compare_select =
    pattern_config[tpr_pkg::TPR_POS_COMPARE_SEL];
  assign pattern_alert_enable =
    pattern_config[tpr_pkg::TPR_POS_ALERT_ENABLE];
  assign threshold_broadcast_write =
    recal_config[tpr_pkg::TPR_POS_BROADCAST];

  // Per input comparison against the pattern threshold
  assign delta[0] = poll_in.delta0;
  assign delta[1] = poll_in.delta1;
  assign delta[2] = poll_in.delta2;
  assign delta[3] = poll_in.delta3;
  assign delta[4] = poll_in.delta4;
  assign delta[5] = poll_in.delta5;
  genvar gi;
  generate
    for (gi = 0; gi < tpr_pkg::TPR_INPUTS; gi++)
    begin : g_hit
      wire [6:0] base;
      assign base = standby_in ? standby_threshold_in : threshold[gi]; // R2
      assign hit[gi] = (delta[gi] > frac(base, pattern_threshold_select))
                     | poll_in.noise[gi]; // R2
    end
  endgenerate

  // Pattern and count conditions on one polling result
  assign pattern_match = ((hit & pattern_mask) == pattern_mask); // R3
  assign count_match = (ones(hit) >= ones(pattern_mask)); // R4
  assign cond_now = pattern_detect_enable
                  & (pattern_compare_select ? pattern_match
                                            : count_match); // R1 R16

  // Wishbone decode: word addresses, low lane carries data
  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wb_wr = wb_req & wb_we_in & sel_ok;
  assign sel_ok = wb_sel_in[0];
  assign wb_idx = wb_adr_in[9:2];
  assign idx_high_zero = (wb_adr_in[31:10] == 22'h00_0000);

  // Condition latch, updated once per polling result
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      cond_active <= 1'b0;
    else if (!pattern_detect_enable)
      cond_active <= 1'b0; // R16
    else if (poll_in.valid)
      cond_active <= cond_now; // R5
  end

  // Touch blocking follows the live condition
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      touch_block_out <= 1'b0;
    else
      touch_block_out <= pattern_detect_enable
                       & (poll_in.valid ? cond_now : cond_active); // R6
  end

  // Sticky event and interrupt flags; set wins over clear
  wire event_set;
  wire int_clear;
  assign event_set = poll_in.valid & cond_now; // R8
  assign int_clear = wb_wr & idx_high_zero
                   & (wb_idx == tpr_pkg::TPR_IDX_STATUS)
                   & ~wb_dat_in[tpr_pkg::TPR_POS_STATUS_INT];
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      pattern_event_flag <= 1'b0;
      int_flag           <= 1'b0;
    end
    else
    begin
      if (event_set)
        pattern_event_flag <= 1'b1; // R8
      else if (int_clear && !cond_active)
        pattern_event_flag <= 1'b0; // R7
      if (event_set && pattern_alert_enable)
        int_flag <= 1'b1; // R8
      else if (int_clear)
        int_flag <= 1'b0;
    end
  end

  // Alert pin, active low
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      alert_n_out <= 1'b1;
    else
      alert_n_out <= ~int_flag; // R8
  end

  // Configuration register writes
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      pattern_config <= tpr_pkg::TPR_RST_PATTERN_CONFIG;
      pattern_mask   <= tpr_pkg::TPR_RST_PATTERN_MASK[5:0]; // R9
      recal_config   <= tpr_pkg::TPR_RST_RECAL_CONFIG;
    end
    else if (wb_wr && idx_high_zero)
    begin
      if (wb_idx == tpr_pkg::TPR_IDX_PATTERN_CONFIG)
        pattern_config <= wb_dat_in[7:0] & 8'h8f;
      if (wb_idx == tpr_pkg::TPR_IDX_PATTERN_MASK)
        pattern_mask <= wb_dat_in[5:0]; // R9
      if (wb_idx == tpr_pkg::TPR_IDX_RECAL_CONFIG)
        recal_config <= wb_dat_in[7:0];
    end
  end

  // Threshold array with broadcast from input one
  generate
    for (gi = 0; gi < tpr_pkg::TPR_INPUTS; gi++)
    begin : g_th
      wire own_wr;
      wire bc_wr;
      assign own_wr = wb_wr & idx_high_zero
                    & (wb_idx == tpr_pkg::TPR_IDX_THRESHOLD_BASE + 8'(gi));
      assign bc_wr = wb_wr & idx_high_zero & threshold_broadcast_write
                   & (wb_idx == tpr_pkg::TPR_IDX_THRESHOLD_BASE); // R10
      always_ff @(posedge mclk_in)
      begin
        if (!rstn_in)
          threshold[gi] <= tpr_pkg::TPR_RST_THRESHOLD[6:0];
        else if (own_wr || bc_wr)
          threshold[gi] <= wb_dat_in[6:0]; // R10
      end
    end
  endgenerate

  // Read data selection
  wire [7:0] rd_byte;
  wire [7:0] status_byte;
  wire       th_hit;
  wire [7:0] th_off;
  assign th_off = wb_idx - tpr_pkg::TPR_IDX_THRESHOLD_BASE;
  assign th_hit = (wb_idx >= tpr_pkg::TPR_IDX_THRESHOLD_BASE)
                & (th_off < 8'h06);
  assign status_byte = {5'h00, cond_active, pattern_event_flag, int_flag};
  assign rd_byte = !idx_high_zero ? 8'h00 :
    (wb_idx == tpr_pkg::TPR_IDX_PATTERN_CONFIG) ? pattern_config :
    (wb_idx == tpr_pkg::TPR_IDX_PATTERN_MASK)   ? {2'h0, pattern_mask} :
    (wb_idx == tpr_pkg::TPR_IDX_RECAL_CONFIG)   ? recal_config :
    (wb_idx == tpr_pkg::TPR_IDX_STATUS)         ? status_byte :
    th_hit ? {1'b0, threshold[th_off[2:0]]} : 8'h00;

  // Bus answer one cycle after the request
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= wb_req;
      wb_dat_out <= wb_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  tpr_recal_decode u_recal
  (
    .cfg_in    (recal_config),
    .noise_in  (noise_status_in),
    .recal_out (next_recal)
  );

  // Registered recalibration settings
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      recal_out <= '0;
    else
      recal_out <= next_recal; // R11 R12 R14 R15
  end

  // Checks
  property p_disabled_quiet;
    @(posedge mclk_in) disable iff (!rstn_in)
    !pattern_detect_enable |=> !touch_block_out;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // R16
    else $error("block while disabled");
  property p_event_sets;
    @(posedge mclk_in) disable iff (!rstn_in)
    event_set |=> pattern_event_flag;
  endproperty
  a_event_sets: assert property (p_event_sets) // R8
    else $error("event flag not set");
  property p_alert_gate;
    @(posedge mclk_in) disable iff (!rstn_in)
    (event_set && pattern_alert_enable) |=> ##1 !alert_n_out;
  endproperty
  a_alert_gate: assert property (p_alert_gate) // R8
    else $error("alert missing");
  property p_flag_hold;
    @(posedge mclk_in) disable iff (!rstn_in)
    $fell(pattern_event_flag) |-> $past(int_clear) && !$past(cond_active);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // R7
    else $error("event flag cleared illegally");
  property p_block_follow;
    @(posedge mclk_in) disable iff (!rstn_in)
    event_set |=> touch_block_out;
  endproperty
  a_block_follow: assert property (p_block_follow) // R6
    else $error("touch not blocked");
  property p_ack_one;
    @(posedge mclk_in) disable iff (!rstn_in)
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_noise_clear;
    @(posedge mclk_in) disable iff (!rstn_in)
    (rstn_in && noise_status_in && !recal_config[tpr_pkg::TPR_POS_KEEP_NEG])
      |=> recal_out.clear_neg;
  endproperty
  a_noise_clear: assert property (p_noise_clear) // R12
    else $error("negative counter not cleared");
  property p_accum_clear;
    @(posedge mclk_in) disable iff (!rstn_in)
    (rstn_in && noise_status_in && !recal_config[tpr_pkg::TPR_POS_KEEP_ACCUM])
      |=> recal_out.clear_accum;
  endproperty
  a_accum_clear: assert property (p_accum_clear) // R11
    else $error("accumulation not cleared");
  c_event: cover property (@(posedge mclk_in) event_set);
  c_clear: cover property (@(posedge mclk_in) $fell(pattern_event_flag));
  c_alert: cover property (@(posedge mclk_in) $fell(alert_n_out));
endmodule : tpr_top

// ==== tpr_wb_host.sv ====
// Wishbone host model issuing classic single cycles
`timescale 1ns/10ps
module tpr_wb_host
(
  input  wire logic        mclk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  output logic      [31:0] adr_out,
  output logic      [31:0] dat_out,
  output logic             we_out,
  output logic             cyc_out
);
  // Idle bus at time zero
  initial
  begin
    adr_out = '0;
    dat_out = '0;
    we_out  = 1'b0;
    cyc_out = 1'b0;
  end

  // One transfer, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk_in);
    cyc_out <= 1'b1;
    we_out  <= w;
    adr_out <= {22'h00_0000, idx, 2'b00};
    dat_out <= {24'h00_0000, wd};
    @(posedge mclk_in);
    while (ack_in !== 1'b1)
      @(posedge mclk_in);
    rd = dat_in[7:0];
    cyc_out <= 1'b0;
    we_out  <= 1'b0;
    adr_out <= ~adr_out;
    dat_out <= ~dat_out;
  endtask : xfer

  // Recalibration setup with both keep bits equal
  task automatic recal(input logic b, input logic k,
                       input logic [1:0] n, input logic [2:0] c);
    logic [7:0] d;
    xfer(1'b1, tpr_pkg::TPR_IDX_RECAL_CONFIG, {b, k, k, n, c}, d);
  endtask : recal
endmodule : tpr_wb_host

// ==== tb.sv ====
// Self-checking bench for touch pattern and recalibration block
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] A_CFG  = tpr_pkg::TPR_IDX_PATTERN_CONFIG;
  localparam logic [7:0] A_MASK = tpr_pkg::TPR_IDX_PATTERN_MASK;
  localparam logic [7:0] A_THR  = tpr_pkg::TPR_IDX_THRESHOLD_BASE;
  localparam logic [7:0] A_ST   = tpr_pkg::TPR_IDX_STATUS;
  logic                   mclk_in;
  logic                   rstn_in;
  logic [31:0]            wb_adr;
  logic [31:0]            wb_wdat;
  logic [31:0]            wb_rdat;
  logic                   wb_we;
  logic                   wb_cyc;
  logic                   wb_ack;
  tpr_pkg::tpr_poll_type  poll_in;
  logic                   standby_in;
  logic                   noise_status_in;
  logic                   touch_block_out;
  logic                   alert_n_out;
  tpr_pkg::tpr_recal_type recal_out;
  logic [7:0]             v;
  logic [47:0]            r;
  int                     failures = 0;
  int                     compares = 0;
  // Rows: config, mask, hit inputs, delta, noise, {standby, event}
  logic [47:0] rows [17] = '{
    48'h8103_0309_0001, 48'h8003_0109_0000, 48'h8003_0109_2001,
    48'h8003_0308_0000, 48'h8205_0309_0000, 48'h8305_0509_0001,
    48'h8205_0109_0401, 48'h8601_0110_0000, 48'h8601_0111_0001,
    48'h8a01_0118_0000, 48'h8a01_0119_0001, 48'h8e01_0140_0000,
    48'h8e01_0141_0001, 48'h0201_017f_0000, 48'h8000_0000_0001,
    48'h8001_0105_0011, 48'h8001_0105_0000};

  tpr_wb_host host
  (
    .mclk_in (mclk_in),
    .ack_in  (wb_ack),
    .dat_in  (wb_rdat),
    .adr_out (wb_adr),
    .dat_out (wb_wdat),
    .we_out  (wb_we),
    .cyc_out (wb_cyc)
  );

  tpr_top dut
  (
    .mclk_in              (mclk_in),
    .rstn_in              (rstn_in),
    .wb_adr_in            (wb_adr),
    .wb_dat_in            (wb_wdat),
    .wb_sel_in            (4'h1),
    .wb_we_in             (wb_we),
    .wb_cyc_in            (wb_cyc),
    .wb_stb_in            (wb_cyc),
    .wb_dat_out           (wb_rdat),
    .wb_ack_out           (wb_ack),
    .poll_in              (poll_in),
    .standby_in           (standby_in),
    .standby_threshold_in (7'h20),
    .noise_status_in      (noise_status_in),
    .touch_block_out      (touch_block_out),
    .alert_n_out          (alert_n_out),
    .recal_out            (recal_out)
  );

  // Clock
  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // Compare tasks
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_recal(input tpr_pkg::tpr_recal_type got,
                           input tpr_pkg::tpr_recal_type exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: recal %h expected %h", $time, got, exp);
    end
  endtask : chk_recal

  // Expected recalibration settings
  function automatic tpr_pkg::tpr_recal_type exp_recal(input logic z,
      input logic k, input logic [1:0] n, input logic [2:0] c);
    tpr_pkg::tpr_recal_type e;
    e.clear_accum   = z & ~k;
    e.clear_neg     = z & ~k;
    e.neg_never     = (n == 2'b11);
    e.neg_trigger   = e.neg_never ? 6'h00 : 6'h08 << n;
    e.samples       = (c > 3'h4) ? 9'h100 : 9'h010 << c;
    e.update_cycles = (c > 3'h4) ? 13'h0400 << (c - 3'h5) : 13'h0010 << c;
    return e;
  endfunction : exp_recal

  // Bus and poll helpers
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, d, v);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    host.xfer(1'b0, idx, 8'h00, v);
    chk8(v, e);
  endtask : rd

  task automatic st(input logic e);
    host.xfer(1'b0, A_ST, 8'h00, v);
    chk_bit(v[1], e);
  endtask : st

  task automatic poll(input logic [5:0] h, input logic [6:0] d,
                      input logic [5:0] n);
    tpr_pkg::tpr_poll_type p;
    p = '0;
    p.valid = 1'b1;
    p.noise = n;
    for (int i = 0; i < 6; i++)
      p[7*(5-i) +: 7] = h[i] ? d : 7'h00;
    @(posedge mclk_in);
    poll_in <= p;
    p = ~p;
    p.valid = 1'b0;
    @(posedge mclk_in);
    poll_in <= p;
    @(negedge mclk_in);
  endtask : poll

  // Verdict
  task automatic tally_and_finish;
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Watchdog
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    rstn_in = 1'b0;
    poll_in = '0;
    standby_in = 1'b0;
    noise_status_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      r = rows[i];
      wr(A_CFG, r[47:40]);
      wr(A_MASK, r[39:32]);
      standby_in <= r[4];
      poll(r[29:24], r[22:16], r[13:8]);
      chk_bit(touch_block_out, r[0]);
      @(negedge mclk_in);
      chk_bit(alert_n_out, ~(r[0] & r[40]));
      st(r[0]);
      standby_in <= 1'b0;
      poll(6'h00, 7'h00, 6'h00);
      wr(A_ST, 8'h00);
      $display("Row %0d done", i);
    end
    wr(A_CFG, 8'hff);
    rd(A_CFG, 8'h8f);
    wr(8'h0f, 8'h55);
    rd(8'h0f, 8'h00);
    $display("Register access test done");
    wr(A_CFG, 8'h80);
    wr(A_MASK, 8'h01);
    poll(6'h01, 7'h09, 6'h00);
    wr(A_ST, 8'h00);
    st(1'b1);
    poll(6'h01, 7'h09, 6'h00);
    chk_bit(touch_block_out, 1'b1);
    poll(6'h00, 7'h00, 6'h00);
    chk_bit(touch_block_out, 1'b0);
    wr(A_ST, 8'h01);
    st(1'b1);
    wr(A_ST, 8'h00);
    st(1'b0);
    $display("Hold and clear test done");
    wr(A_THR, 8'h20);
    rd(A_THR + 8'h05, 8'h20);
    wr(A_THR + 8'h03, 8'h10);
    rd(A_THR + 8'h03, 8'h10);
    rd(A_THR + 8'h04, 8'h20);
    host.recal(1'b0, 1'b0, 2'b01, 3'b010);
    wr(A_THR, 8'h30);
    rd(A_THR + 8'h01, 8'h20);
    $display("Broadcast test done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk_in);
      noise_status_in <= i[1];
      host.recal(1'b1, i[0], i[1:0], i[2:0]);
      @(negedge mclk_in);
      chk_recal(recal_out, exp_recal(i[1], i[0], i[1:0], i[2:0]));
    end
    $display("Recalibration decode test done");
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(negedge mclk_in);
    chk_bit(touch_block_out, 1'b0);
    chk_bit(alert_n_out, 1'b1);
    rd(A_CFG, 8'h00);
    rd(A_MASK, 8'h3f);
    rd(tpr_pkg::TPR_IDX_RECAL_CONFIG, 8'h8a);
    rd(A_THR + 8'h05, 8'h40);
    chk_recal(recal_out, exp_recal(1'b1, 1'b0, 2'b01, 3'b010));
    $display("Reset test done");
    tally_and_finish();
  end
endmodule : tb
